/* File: logic/iasb_adc_seq.sv */
// Notes on behaviour
// - Busy rises at de-integrate, high 836 cycles
// - Result valid at busy falling edge
// - Busy driven in both modes
// - Oscillator divided by four, 1280-cycle conversion
// - Integrate phase lasts 256 internal cycles
// - Demand mode: one conversion per selected strobe
// - Demand mode: only strobe falling edge starts conversion
// - Busy falls 1155 cycles after strobe
// - 125 cycles after busy fall before next
// - Strobe ignored 1100 cycles, later one queued
// - Data held until next busy rise
// - Demand reads bytes in any order
// - Continuous mode converts back to back
// - Continuous ignores byte and flag selects
// - Chip select AND enable qualify strobes
// - High byte top line polarity or overrange
// - Continuous order: hi-pol, low, hi-ovr
// - Byte counter advances on read release
`timescale 1ns/1ns
`default_nettype none
module iasb_adc_seq
    import iasb_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic oscillator_input,
    input wire logic chip_select,
    input wire logic chip_enable_n,
    input wire logic conv_strobe_n,
    input wire logic read_strobe_n,
    input wire logic mode_select,
    input wire logic byte_select,
    input wire logic flag_select,
    input wire logic [14:0] result_in,
    input wire logic polarity_in,
    input wire logic overrange_in,
    output logic busy,
    output logic integrate,
    output logic data_valid,
    output logic [7:0] data_out,
    output logic data_oe
);
    import iasb_pkg::*;

    // ******************************
    // Pin synchronisers
    // ******************************
    logic [PIN_COUNT-1:0] pins_s;
    logic osc_s;
    logic cs_s;
    logic ce_n_s;
    logic wr_n_s;
    logic rd_n_s;
    logic mode_s;
    logic bsel_s;
    logic fsel_s;
    logic selected;
    logic strobe_act;
    logic read_act;

    iasb_pin_sync #(
        .WIDTH(PIN_COUNT),
        .RESET_VALUE(PIN_RESET)
    ) iasb_pin_sync_inst (
        .clk(clk),
        .reset_n(reset_n),
        .pins({flag_select, byte_select, mode_select, read_strobe_n, conv_strobe_n,
               chip_enable_n, chip_select, oscillator_input}),
        .pins_sync(pins_s)
    );

    assign {fsel_s, bsel_s, mode_s, rd_n_s, wr_n_s, ce_n_s, cs_s, osc_s} = pins_s;

    assign selected = cs_s & ~ce_n_s;
    assign strobe_act = selected & ~wr_n_s;
    assign read_act = selected & ~rd_n_s;

    // ******************************
    // Internal clock divider
    // ******************************
    logic osc_prev_q;
    logic osc_prev_d;
    logic [1:0] div_q;
    logic [1:0] div_d;
    logic tick;

    always_comb begin
        osc_prev_d = reset_n ? osc_s : 1'b0;
        div_d = div_q;
        tick = 1'b0;
        if (osc_s && !osc_prev_q) begin
            tick = (div_q == OSC_DIV_LAST);
            div_d = div_q + 2'h1;
        end
        if (!reset_n) begin
            div_d = 2'h0;
            tick = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        osc_prev_q <= osc_prev_d;
        div_q <= div_d;
    end

    // ******************************
    // Conversion sequencer
    // ******************************
    iasb_state_t st_q;
    iasb_state_t st_d;
    logic [10:0] cnt_q;
    logic [10:0] cnt_d;
    logic strobe_prev_q;
    logic strobe_prev_d;
    logic pend_q;
    logic pend_d;
    logic busy_q;
    logic busy_d;
    logic integ_q;
    logic integ_d;
    logic strobe_fall;
    logic pend_now;

    // strobe edge seen only on internal ticks
    // edge, not level, starts a conversion
    assign strobe_fall = tick & strobe_act & ~strobe_prev_q;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        pend_d = pend_q;
        strobe_prev_d = strobe_prev_q;
        // strobes inside the blind window are dropped
        pend_now = pend_q | (strobe_fall & ~mode_s & (cnt_q >= STROBE_IGNORE));
        if (tick) begin
            strobe_prev_d = strobe_act;
            unique case (st_q)
                ST_IDLE: begin
                    if (mode_s || strobe_fall) begin
                        st_d = ST_RUN;
                        cnt_d = 11'h000;
                    end
                end
                ST_RUN: begin
                    pend_d = pend_now;
                    if (cnt_q == CONV_LAST) begin
                        // next conversion only after the post phase
                        if (mode_s || pend_now) begin
                            cnt_d = 11'h000;
                        end else begin
                            st_d = ST_IDLE;
                        end
                        pend_d = 1'b0;
                    end else begin
                        cnt_d = cnt_q + 11'h001;
                    end
                end
            endcase
        end
        busy_d = (st_d == ST_RUN) && (cnt_d >= BUSY_RISE_AT) && (cnt_d < BUSY_FALL_AT);
        integ_d = (st_d == ST_RUN) && (cnt_d >= INTEG_START) && (cnt_d < BUSY_RISE_AT);
        if (!reset_n) begin
            st_d = ST_IDLE;
            cnt_d = 11'h000;
            pend_d = 1'b0;
            strobe_prev_d = 1'b1;
            busy_d = 1'b0;
            integ_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        st_q <= st_d;
        cnt_q <= cnt_d;
        pend_q <= pend_d;
        strobe_prev_q <= strobe_prev_d;
        busy_q <= busy_d;
        integ_q <= integ_d;
    end

    assign busy = busy_q;
    assign integrate = integ_q;

    // ******************************
    // Result hold and read port
    // ******************************
    logic [14:0] res_q;
    logic [14:0] res_d;
    logic pol_q;
    logic pol_d;
    logic ovr_q;
    logic ovr_d;
    logic valid_q;
    logic valid_d;
    iasb_byte_t byte_q;
    iasb_byte_t byte_d;
    logic read_prev_q;
    logic read_prev_d;
    logic [7:0] dout_q;
    logic [7:0] dout_d;
    logic oe_q;
    logic oe_d;
    logic capture;

    assign capture = busy_q & ~busy_d;

    always_comb begin
        res_d = res_q;
        pol_d = pol_q;
        ovr_d = ovr_q;
        valid_d = valid_q;
        byte_d = byte_q;
        read_prev_d = read_act;
        if (capture) begin
            res_d = result_in;
            pol_d = polarity_in;
            ovr_d = overrange_in;
            valid_d = 1'b1;
            byte_d = BYTE_HI_POL;
        end else if (busy_d && !busy_q) begin
            // held data stays until busy rises again
            valid_d = 1'b0;
            byte_d = BYTE_HI_POL;
        end else if (mode_s && read_prev_q && !read_act) begin
            // read release steps the byte counter
            unique case (byte_q)
                BYTE_HI_POL: byte_d = BYTE_LO;
                BYTE_LO: byte_d = BYTE_HI_OVR;
                BYTE_HI_OVR: byte_d = BYTE_HI_POL;
                default: byte_d = BYTE_HI_POL;
            endcase
        end
        // high byte top line carries polarity or overrange
        // demand reads addressed by the select inputs
        if (!mode_s) begin
            if (bsel_s) begin
                dout_d = res_q[7:0];
            end else begin
                dout_d = {fsel_s ? ovr_q : pol_q, res_q[14:8]};
            end
        end else begin
            unique case (byte_q)
                BYTE_HI_POL: dout_d = {pol_q, res_q[14:8]};
                BYTE_LO: dout_d = res_q[7:0];
                BYTE_HI_OVR: dout_d = {ovr_q, res_q[14:8]};
                default: dout_d = {pol_q, res_q[14:8]};
            endcase
        end
        oe_d = read_act;
        if (!reset_n) begin
            res_d = 15'h0000;
            pol_d = 1'b0;
            ovr_d = 1'b0;
            valid_d = 1'b0;
            byte_d = BYTE_HI_POL;
            read_prev_d = 1'b0;
            dout_d = 8'h00;
            oe_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        res_q <= res_d;
        pol_q <= pol_d;
        ovr_q <= ovr_d;
        valid_q <= valid_d;
        byte_q <= byte_d;
        read_prev_q <= read_prev_d;
        dout_q <= dout_d;
        oe_q <= oe_d;
    end

    assign data_valid = valid_q;
    assign data_out = dout_q;
    assign data_oe = oe_q;

    // ******************************
    // Assertions
    // ******************************
    logic [10:0] busy_len_q;
    logic [10:0] integ_len_q;
    logic first_rd_q;
    always_ff @(posedge clk) begin
        busy_len_q <= !busy_q ? 11'h000 : busy_len_q + {10'h000, tick};
        integ_len_q <= !integ_q ? 11'h000 : integ_len_q + {10'h000, tick};
        // Held result whose first continuous byte has not been released yet
        if (!reset_n || (mode_s && read_prev_q && !read_act && !capture)) begin
            first_rd_q <= 1'b0;
        end else if (capture) begin
            first_rd_q <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_busy_len;
        $fell(busy_q) |-> busy_len_q == BUSY_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy width wrong");

    property p_integ_len;
        $fell(integ_q) |-> integ_len_q == INTEG_CYCLES;
    endproperty
    a_integ_len: assert property (p_integ_len) else $error("integrate width wrong");

    property p_busy_fall_at;
        $fell(busy_q) |-> cnt_q == BUSY_FALL_AT && $past(tick);
    endproperty
    a_busy_fall_at: assert property (p_busy_fall_at) else $error("busy fell off cycle");

    property p_capture;
        $fell(busy_q) |-> valid_q && res_q == $past(result_in);
    endproperty
    a_capture: assert property (p_capture) else $error("result not captured");

    property p_count_range;
        cnt_q <= CONV_LAST && (st_q == ST_RUN || st_q == ST_IDLE);
    endproperty
    a_count_range: assert property (p_count_range) else $error("count past conversion");

    property p_edge_start;
        $rose(st_q == ST_RUN) |-> $past(mode_s) || $past(strobe_fall);
    endproperty
    a_edge_start: assert property (p_edge_start) else $error("start without edge");

    property p_blind;
        st_q == ST_RUN && !pend_q && cnt_q < STROBE_IGNORE && cnt_q != CONV_LAST |=> !pend_q;
    endproperty
    a_blind: assert property (p_blind) else $error("strobe queued in blind window");

    property p_cont_first;
        $past(mode_s) && $past(first_rd_q) && oe_q
            |-> dout_q == {$past(pol_q), $past(res_q[14:8])};
    endproperty
    a_cont_first: assert property (p_cont_first) else $error("first byte not high/pol");

    property p_oe_select;
        oe_q |-> $past(selected) && $past(!rd_n_s);
    endproperty
    a_oe_select: assert property (p_oe_select) else $error("bus driven unselected");

    c_demand_conv: cover property ($fell(busy_q) && !mode_s);
    c_cont_back: cover property (mode_s && $rose(busy_q) && $past(valid_q));
    c_queued: cover property (pend_q && cnt_q == CONV_LAST);
endmodule : iasb_adc_seq
`default_nettype wire

/* File: shared/iasb_pkg.sv */
`default_nettype none
package iasb_pkg;
    // ******************************
    // Internal clock and conversion
    // ******************************
    localparam logic [2:0] OSC_DIV = 3'h4;
    localparam logic [1:0] OSC_DIV_LAST = 2'(OSC_DIV - 3'h1);
    localparam logic [10:0] CONV_CYCLES = 11'h500;
    localparam logic [10:0] CONV_LAST = CONV_CYCLES - 11'h001;
    localparam logic [10:0] INTEG_CYCLES = 11'h100;
    localparam logic [10:0] BUSY_CYCLES = 11'h344;
    localparam logic [10:0] BUSY_FALL_AT = 11'h483;
    localparam logic [10:0] POST_CYCLES = CONV_CYCLES - BUSY_FALL_AT;
    localparam logic [10:0] BUSY_RISE_AT = BUSY_FALL_AT - BUSY_CYCLES;
    localparam logic [10:0] INTEG_START = BUSY_RISE_AT - INTEG_CYCLES;
    localparam logic [10:0] STROBE_IGNORE = 11'h44C;
    localparam int unsigned PIN_COUNT = 8;
    // Sync reset: oscillator low, unselected, both strobes idle high
    localparam logic [PIN_COUNT-1:0] PIN_RESET = 8'h1C;

    // ******************************
    // States and byte order
    // ******************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_RUN = 2'h2
    } iasb_state_t;

    typedef enum logic [2:0] {
        BYTE_HI_POL = 3'h1,
        BYTE_LO = 3'h2,
        BYTE_HI_OVR = 3'h4
    } iasb_byte_t;
endpackage : iasb_pkg
`default_nettype wire

/* File: logic/iasb_pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module iasb_pin_sync #(
    parameter int unsigned WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] pins,
    output logic [WIDTH-1:0] pins_sync
);
    // Two flops per pin; the first stage feeds only the second
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_comb begin
                meta_d[i] = reset_n ? pins[i] : RESET_VALUE[i];
                sync_d[i] = reset_n ? meta_q[i] : RESET_VALUE[i];
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign pins_sync = sync_q;
endmodule : iasb_pin_sync
`default_nettype wire

/* File: dv/iasb_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ******************************
// Processor side of the read port
// ******************************
module iasb_host_model (
    input wire logic clk,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    output logic chip_select,
    output logic chip_enable_n,
    output logic conv_strobe_n,
    output logic read_strobe_n,
    output logic byte_select,
    output logic flag_select
);
    initial begin
        chip_select = 1'b1;
        chip_enable_n = 1'b0;
        conv_strobe_n = 1'b1;
        read_strobe_n = 1'b1;
        byte_select = 1'b0;
        flag_select = 1'b0;
    end

    task automatic select(input logic cs, input logic ce_n);
        @(negedge clk);
        chip_select = cs;
        chip_enable_n = ce_n;
    endtask : select

    task automatic drive_wr(input logic v);
        @(negedge clk);
        conv_strobe_n = v;
    endtask : drive_wr

    // one byte, strobe released after it
    task automatic read_byte(input logic bs, input logic fs, output logic [7:0] d,
                             output logic oe);
        @(negedge clk);
        byte_select = bs;
        flag_select = fs;
        read_strobe_n = 1'b0;
        repeat (5) @(negedge clk);
        d = data_out;
        oe = data_oe;
        read_strobe_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask : read_byte
endmodule : iasb_host_model
`default_nettype wire

/* File: dv/test_integrating_adc_sequencer_bus_port.sv */
`timescale 1ns/1ns
`default_nettype none
module test_integrating_adc_sequencer_bus_port;
    import iasb_pkg::*;
    // One internal cycle is eight clocks with the oscillator at half rate
    localparam int T = 8;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic osc = 1'b0;
    logic mode_select = 1'b0;
    logic [14:0] result_in = 15'h5A3C;
    logic polarity_in = 1'b1;
    logic overrange_in = 1'b0;
    logic cs;
    logic ce_n;
    logic wr_n;
    logic rd_n;
    logic bs;
    logic fs;
    logic busy;
    logic integrate;
    logic data_valid;
    logic data_oe;
    logic [7:0] data_out;
    int n_fail = 0;
    int n_checks = 0;
    int c1;
    int c2;

    always #2 clk = ~clk;
    always @(negedge clk) osc <= ~osc;

    iasb_host_model iasb_host_model_inst (.clk(clk), .data_out(data_out), .data_oe(data_oe),
        .chip_select(cs), .chip_enable_n(ce_n), .conv_strobe_n(wr_n), .read_strobe_n(rd_n),
        .byte_select(bs), .flag_select(fs));

    iasb_adc_seq iasb_adc_seq_inst (.clk(clk), .reset_n(reset_n), .oscillator_input(osc),
        .chip_select(cs), .chip_enable_n(ce_n), .conv_strobe_n(wr_n), .read_strobe_n(rd_n),
        .mode_select(mode_select), .byte_select(bs), .flag_select(fs), .result_in(result_in),
        .polarity_in(polarity_in), .overrange_in(overrange_in), .busy(busy),
        .integrate(integrate), .data_valid(data_valid), .data_out(data_out), .data_oe(data_oe));

    // ******************************
    // Shared tasks
    // ******************************
    task automatic end_sim;
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic near(input int seen, input int lo, input int hi);
        check({31'h0, seen >= lo && seen <= hi}, 32'h1);
    endtask : near

    // Counts clocks until the chosen flag reaches val; a stuck flag ends the run
    task automatic wait_sig(input logic integ, input logic val, input int lim, output int cnt);
        cnt = 0;
        while ((integ ? integrate : busy) !== val) begin
            @(negedge clk);
            cnt++;
            if (cnt > lim) begin
                check(cnt, lim);
                end_sim();
            end
        end
    endtask : wait_sig

    task automatic pulse;
        iasb_host_model_inst.drive_wr(1'b0);
        repeat (3 * T) @(negedge clk);
        iasb_host_model_inst.drive_wr(1'b1);
    endtask : pulse

    task automatic rd(input logic b, input logic f, input logic [7:0] exp);
        logic [7:0] d;
        logic oe;
        iasb_host_model_inst.read_byte(b, f, d, oe);
        check({24'h0, d}, {24'h0, exp});
        check({31'h0, oe}, 32'h1);
    endtask : rd

    // ******************************
    // Scenarios
    // ******************************
    task automatic demand_conv;
        iasb_host_model_inst.drive_wr(1'b0);
        wait_sig(1'b0, 1'b1, 330 * T, c1);
        near(c1, 319 * T, 319 * T + 16);
        wait_sig(1'b0, 1'b0, 840 * T, c2);
        check(c2, 836 * T);
        near(c1 + c2, 1155 * T, 1155 * T + 16);
        check({31'h0, data_valid}, 32'h1);
        // Strobe still held low: a level must not restart
        repeat (450 * T) @(negedge clk);
        check({31'h0, busy}, 32'h0);
        iasb_host_model_inst.drive_wr(1'b1);
        rd(1'b1, 1'b0, 8'h3C);
        rd(1'b0, 1'b1, 8'h5A);
        rd(1'b0, 1'b0, 8'hDA);
        check({31'h0, data_valid}, 32'h1);
    endtask : demand_conv

    task automatic unselected;
        logic [7:0] d;
        logic oe;
        for (int i = 0; i < 2; i++) begin
            iasb_host_model_inst.select(1'(i), 1'(i));
            pulse();
            repeat (400 * T) @(negedge clk);
            check({31'h0, busy}, 32'h0);
            iasb_host_model_inst.read_byte(1'b0, 1'b0, d, oe);
            check({31'h0, oe}, 32'h0);
        end
        iasb_host_model_inst.select(1'b1, 1'b0);
    endtask : unselected

    task automatic queued;
        pulse();
        wait_sig(1'b0, 1'b1, 330 * T, c1);
        repeat (278 * T) @(negedge clk);
        pulse();
        wait_sig(1'b0, 1'b0, 600 * T, c2);
        repeat (450 * T) @(negedge clk);
        check({31'h0, busy}, 32'h0);
        pulse();
        wait_sig(1'b0, 1'b1, 330 * T, c1);
        repeat (795 * T) @(negedge clk);
        pulse();
        wait_sig(1'b0, 1'b0, 60 * T, c2);
        wait_sig(1'b0, 1'b1, 450 * T, c2);
        check(c2, 444 * T);
        wait_sig(1'b0, 1'b0, 840 * T, c2);
    endtask : queued

    task automatic cont_conv;
        result_in = 15'h2B81;
        polarity_in = 1'b0;
        overrange_in = 1'b1;
        mode_select = 1'b1;
        wait_sig(1'b1, 1'b1, 1400 * T, c1);
        wait_sig(1'b1, 1'b0, 260 * T, c2);
        check(c2, 256 * T);
        wait_sig(1'b0, 1'b0, 840 * T, c2);
        check(c2, 836 * T);
        // Selects held at the values that demand mode would obey
        rd(1'b1, 1'b1, 8'h2B);
        rd(1'b1, 1'b1, 8'h81);
        rd(1'b1, 1'b1, 8'hAB);
        wait_sig(1'b0, 1'b1, 450 * T, c1);
        check(c1 + 36, 444 * T);
        check({31'h0, data_valid}, 32'h0);
    endtask : cont_conv

    initial begin
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        // The strobe edge detector only learns the idle level at the first internal tick
        repeat (3 * T) @(negedge clk);
        demand_conv();
        unselected();
        queued();
        cont_conv();
        end_sim();
    end
endmodule : test_integrating_adc_sequencer_bus_port
`default_nettype wire
